// >>> design/drp_top.sv
// refresh, self-refresh and power-down state handling of the dram device
// assumes ck from the controller; clock is the device's own oscillator
`timescale 1ns/1ps
`default_nettype none
`include "drp_map.svh"

module drp_top
    import drp_pkg::*;
#(
    parameter int TRFC_CK = `DRP_TRFC_CK,
    parameter int TCPDED_CK = `DRP_TCPDED_CK,
    parameter int TREFI_CYC = `DRP_TREFI_CYC,
    parameter int ROW_W = `DRP_ROW_W
) (
    input wire logic clock, // core oscillator, 100 MHz
    input wire logic resetn, // device reset pin, async low
    input wire logic clock_en, // freezes all state when low
    input wire logic ck, // controller clock
    input wire drp_cmd_type cmd, // command pins
    input wire logic cke, // clock enable pin
    input wire logic [2:0] bank, // bank address pins
    input wire logic a10, // precharge-all address pin
    input wire logic wr_strobe_err, // strobe timing fault of this write
    input wire logic dll_off_mode, // mode bit: dll disabled
    input wire logic pd_dll_fast, // mode bit: dll kept in precharge pd
    output logic [4:0] dev_state, // one-hot device state
    output logic [7:0] bank_open, // open row per bank
    output logic dll_enable, // dll running
    output logic dll_reset, // dll reset pulse
    output logic cmd_rx_en, // command receivers on
    output logic wr_suspect, // write data may be wrong
    output logic int_refresh, // internal refresh pulse
    output logic [ROW_W-1:0] refresh_row // row being refreshed
);

    // ----------------------------------------------------------------
    // link side: pin registers and state machine on ck
    // ----------------------------------------------------------------
    drp_state_type state, next_state;
    drp_cmd_type cmd_q;
    logic cke_q, cke_prev, a10_q, wr_err_q;
    logic [2:0] bank_q;
    logic [7:0] next_bank_open;
    logic [`DRP_CNT_W-1:0] cnt, next_cnt;
    logic next_dll_enable, next_dll_reset, next_cmd_rx_en, next_wr_suspect;
    logic ref_tgl, next_ref_tgl;
    logic is_ref, is_nop, is_pd_kind;

    always_comb begin
        is_ref = (cmd_q == `DRP_CMD_REF);
        is_nop = cmd_q.cs_n || (cmd_q == `DRP_CMD_NOP);
        is_pd_kind = 1'b0;
        next_state = state;
        next_bank_open = bank_open;
        next_cnt = cnt;
        next_dll_enable = dll_enable;
        next_dll_reset = 1'b0;
        next_cmd_rx_en = cmd_rx_en;
        next_wr_suspect = 1'b0;
        next_ref_tgl = ref_tgl;
        case (state)
            ST_NORMAL: begin
                if (cke_prev && !cke_q && is_ref) begin
                    next_state = ST_SELF_REF;
                    next_bank_open = `DRP_BANK_RST;
                    next_dll_enable = 1'b0;
                    next_ref_tgl = ~ref_tgl;
                end else if (cke_prev && !cke_q && is_nop) begin
                    is_pd_kind = |bank_open;
                    next_state = is_pd_kind ? ST_PD_ACT : ST_PD_PRE;
                    if (!is_pd_kind && !pd_dll_fast) begin
                        next_dll_enable = 1'b0;
                    end
                    next_cnt = `DRP_CNT_W'(TCPDED_CK);
                end else if (cke_q && is_ref) begin
                    next_state = ST_REFRESH;
                    next_bank_open = `DRP_BANK_RST;
                    next_cnt = `DRP_CNT_W'(TRFC_CK - 1);
                    next_ref_tgl = ~ref_tgl;
                end else if (cke_q && cmd_q == `DRP_CMD_ACT) begin
                    next_bank_open[bank_q] = 1'b1;
                end else if (cke_q && cmd_q == `DRP_CMD_PRE) begin
                    if (a10_q) begin
                        next_bank_open = `DRP_BANK_RST;
                    end else begin
                        next_bank_open[bank_q] = 1'b0;
                    end
                end else if (cke_q && cmd_q == `DRP_CMD_WR && wr_err_q) begin
                    next_wr_suspect = 1'b1;
                end
            end
            ST_REFRESH: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else if (!cke_q) begin
                    next_state = ST_PD_PRE;
                    next_cnt = `DRP_CNT_W'(TCPDED_CK);
                    if (!pd_dll_fast) begin
                        next_dll_enable = 1'b0;
                    end
                end else begin
                    next_state = ST_NORMAL;
                end
            end
            ST_SELF_REF: begin
                if (cke_q) begin
                    next_state = ST_NORMAL;
                    next_dll_enable = !dll_off_mode;
                    next_dll_reset = !dll_off_mode;
                end
            end
            ST_PD_PRE, ST_PD_ACT: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else begin
                    next_cmd_rx_en = 1'b0;
                end
                if (cke_q) begin
                    next_state = ST_NORMAL;
                    next_cmd_rx_en = 1'b1;
                    next_dll_enable = !dll_off_mode;
                end
            end
            default: begin
                next_state = ST_NORMAL;
            end
        endcase
    end

    // reset pin acts asynchronously, also out of power-down
    always_ff @(posedge ck or negedge resetn) begin
        if (!resetn) begin
            state <= ST_NORMAL;
            cmd_q <= '1;
            cke_q <= 1'b0;
            cke_prev <= 1'b0;
            bank_q <= 3'h0;
            a10_q <= 1'b0;
            wr_err_q <= 1'b0;
            bank_open <= `DRP_BANK_RST;
            cnt <= '0;
            dll_enable <= 1'b0;
            dll_reset <= 1'b0;
            cmd_rx_en <= 1'b1;
            wr_suspect <= 1'b0;
            ref_tgl <= 1'b0;
        end else if (clock_en) begin
            state <= next_state;
            cmd_q <= cmd;
            cke_q <= cke;
            cke_prev <= cke_q;
            bank_q <= bank;
            a10_q <= a10;
            wr_err_q <= wr_strobe_err;
            bank_open <= next_bank_open;
            cnt <= next_cnt;
            dll_enable <= next_dll_enable;
            dll_reset <= next_dll_reset;
            cmd_rx_en <= next_cmd_rx_en;
            wr_suspect <= next_wr_suspect;
            ref_tgl <= next_ref_tgl;
        end
    end

    assign dev_state = state;

    // ----------------------------------------------------------------
    // core side: refresh engine and self-refresh timer on clock
    // ----------------------------------------------------------------
    logic [2:0] ref_sync, next_ref_sync;
    logic [2:0] sr_sync, next_sr_sync;
    logic [15:0] timer, next_timer;
    logic [ROW_W-1:0] next_refresh_row;
    logic next_int_refresh, do_ref;

    always_comb begin
        next_ref_sync = {ref_sync[1:0], ref_tgl};
        next_sr_sync = {sr_sync[1:0], state == ST_SELF_REF};
        do_ref = 1'b0;
        next_timer = timer;
        if (sr_sync[1] && !sr_sync[2]) begin
            do_ref = 1'b1;
            next_timer = 16'(TREFI_CYC - 1);
        end else if (sr_sync[1]) begin
            if (timer == 16'h0000) begin
                do_ref = 1'b1;
                next_timer = 16'(TREFI_CYC - 1);
            end else begin
                next_timer = timer - 16'h0001;
            end
        end else if (ref_sync[1] != ref_sync[2]) begin
            do_ref = 1'b1;
        end
        next_int_refresh = do_ref;
        next_refresh_row = do_ref ? refresh_row + 1'b1 : refresh_row;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ref_sync <= 3'h0;
            sr_sync <= 3'h0;
            timer <= 16'h0000;
            int_refresh <= 1'b0;
            refresh_row <= '0;
        end else if (clock_en) begin
            ref_sync <= next_ref_sync;
            sr_sync <= next_sr_sync;
            timer <= next_timer;
            int_refresh <= next_int_refresh;
            refresh_row <= next_refresh_row;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic [`DRP_CNT_W-1:0] ref_len;

    always_ff @(posedge ck or negedge resetn) begin
        if (!resetn) begin
            ref_len <= '0;
        end else if (clock_en) begin
            ref_len <= (state == ST_REFRESH) ? ref_len + 1'b1 : '0;
        end
    end

    a_ref_entry: assert property (@(posedge ck) disable iff (!resetn)
        clock_en && state == ST_NORMAL && cke_prev && cke_q && is_ref |=> state == ST_REFRESH)
        else $error("refresh command not taken");

    a_ref_length: assert property (@(posedge ck) disable iff (!resetn)
        clock_en && $fell(state == ST_REFRESH) |-> ref_len == `DRP_CNT_W'(TRFC_CK)
        && bank_open == `DRP_BANK_RST)
        else $error("refresh length or bank state wrong");

    a_sr_entry: assert property (@(posedge ck) disable iff (!resetn)
        clock_en && state == ST_NORMAL && cke_prev && !cke_q && is_ref
        |=> state == ST_SELF_REF && !dll_enable)
        else $error("self-refresh entry missed");

    a_sr_hold: assert property (@(posedge ck) disable iff (!resetn)
        clock_en && state == ST_SELF_REF && !cke_q |=> state == ST_SELF_REF)
        else $error("self-refresh left without cke");

    a_sr_dll_reset: assert property (@(posedge ck) disable iff (!resetn)
        clock_en && $fell(state == ST_SELF_REF) |-> dll_reset == !$past(dll_off_mode))
        else $error("dll reset missing on exit");

    a_pd_kind: assert property (@(posedge ck) disable iff (!resetn)
        clock_en && state == ST_NORMAL && cke_prev && !cke_q && is_nop && !is_ref
        |=> (state == ST_PD_ACT) == ($past(bank_open) != 8'h00))
        else $error("wrong power-down kind");

    a_pd_dll: assert property (@(posedge ck) disable iff (!resetn)
        clock_en && state == ST_PD_PRE && !pd_dll_fast && $stable(state) |-> !dll_enable)
        else $error("dll on in slow power-down");

    a_rx_off: assert property (@(posedge ck) disable iff (!resetn)
        clock_en && $rose(state == ST_PD_ACT) ##1 clock_en && cke_q == 1'b0 && cke == 1'b0
        [*2] |-> !cmd_rx_en || TCPDED_CK > 1)
        else $error("receivers still on in power-down");

    a_wr_fault: assert property (@(posedge ck) disable iff (!resetn)
        clock_en && state == ST_NORMAL && cke_q && cmd_q == `DRP_CMD_WR && wr_err_q
        |=> wr_suspect && state == ST_NORMAL)
        else $error("write fault changed device state");

    a_sr_first_ref: assert property (@(posedge clock) disable iff (!resetn)
        clock_en && sr_sync[1] && !sr_sync[2] |=> int_refresh)
        else $error("no refresh on self-refresh entry");

endmodule : drp_top
`default_nettype wire

// >>> design/drp_map.svh
// constants of the refresh and power-down state block
// assumes a 100 MHz core clock and command pins timed to ck
`ifndef DRP_MAP_SVH
`define DRP_MAP_SVH

// command pin patterns {cs_n, ras_n, cas_n, we_n}
`define DRP_CMD_REF 4'h1
`define DRP_CMD_PRE 4'h2
`define DRP_CMD_ACT 4'h3
`define DRP_CMD_WR 4'h4
`define DRP_CMD_NOP 4'h7

// timing
`define DRP_CLOCK_MHZ 100
`define DRP_TREFI_NS 7800
`define DRP_TREFI_CYC ((`DRP_TREFI_NS * `DRP_CLOCK_MHZ) / 1000)
`define DRP_TRFC_CK 6
`define DRP_TCPDED_CK 1

// widths and reset values
`define DRP_BANKS 8
`define DRP_ROW_W 13
`define DRP_CNT_W 8
`define DRP_BANK_RST 8'h00

`endif

// >>> design/drp_pkg.sv
// types shared by the refresh and power-down state block
// assumes nothing beyond the map header
package drp_pkg;

    // one-hot link-side device state
    typedef enum logic [4:0] {
        ST_NORMAL   = 5'b0_0001,
        ST_REFRESH  = 5'b0_0010,
        ST_SELF_REF = 5'b0_0100,
        ST_PD_PRE   = 5'b0_1000,
        ST_PD_ACT   = 5'b1_0000
    } drp_state_type;

    // command pins as registered from the bus
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } drp_cmd_type;

endpackage : drp_pkg

// >>> test/drp_ctrl_model.sv
// controller-side model driving the dram command and cke pins
// assumes the bench calls send; pins change at the ck falling edge
`timescale 1ns/1ps
`default_nettype none
`include "drp_map.svh"
module drp_ctrl_model
    import drp_pkg::*;
(
    input wire logic ck, // controller clock
    output drp_cmd_type cmd, // command pins
    output logic cke, // clock enable pin
    output logic [2:0] bank, // bank address pins
    output logic a10, // precharge-all pin
    output logic wr_strobe_err // strobe fault of this write
);
    initial begin
        cmd = `DRP_CMD_NOP;
        cke = 1'b1;
        bank = 3'h0;
        a10 = 1'b0;
        wr_strobe_err = 1'b0;
    end
    // ----------------------------------------------------------------
    // one command for one ck edge, then nop with cke held
    // ----------------------------------------------------------------
    task automatic send(input logic [3:0] c, input logic k, input logic [2:0] b,
                        input logic e);
        @(negedge ck);
        cmd = c;
        cke = k;
        bank = b;
        a10 = (c == `DRP_CMD_PRE);
        wr_strobe_err = e;
        @(posedge ck);
        @(negedge ck);
        cmd = `DRP_CMD_NOP;
        bank = ~b;
        a10 = ~a10;
        wr_strobe_err = 1'b0;
    endtask : send
endmodule : drp_ctrl_model
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench of the refresh and power-down state block
// assumes drp_top and the controller model; ck stops only in self-refresh
`timescale 1ns/1ps
`default_nettype none
`include "drp_map.svh"
module tb_top;
    import drp_pkg::*;
    localparam int TRFC = 6;
    logic clock, resetn, ck, ck_run, pd_dll_fast;
    drp_cmd_type cmd;
    logic cke, a10, wr_strobe_err, dll_enable, dll_reset, cmd_rx_en, wr_suspect, int_refresh;
    logic [2:0] bank, b;
    logic [4:0] dev_state;
    logic [7:0] bank_open, open0;
    logic [12:0] refresh_row;
    logic e;
    int miscompares = 0, cmp_count = 0, n_ref = 0, n0 = 0, seed = 12818;
    drp_top #(.TRFC_CK(TRFC), .TCPDED_CK(1), .TREFI_CYC(20), .ROW_W(13)) DUT (
        .clock(clock), .resetn(resetn), .clock_en(1'b1), .ck(ck), .cmd(cmd), .cke(cke),
        .bank(bank), .a10(a10), .wr_strobe_err(wr_strobe_err), .dll_off_mode(1'b0),
        .pd_dll_fast(pd_dll_fast), .dev_state(dev_state), .bank_open(bank_open),
        .dll_enable(dll_enable), .dll_reset(dll_reset), .cmd_rx_en(cmd_rx_en),
        .wr_suspect(wr_suspect), .int_refresh(int_refresh), .refresh_row(refresh_row));
    drp_ctrl_model pm (.ck(ck), .cmd(cmd), .cke(cke), .bank(bank), .a10(a10),
        .wr_strobe_err(wr_strobe_err));
    always #5 clock = ~clock;
    initial begin
        ck = 1'b0;
        #7;
        forever #15 ck = ck_run ? ~ck : 1'b0;
    end
    always @(posedge clock) begin
        if (!resetn) n_ref <= 0;
        else if (int_refresh === 1'b1) n_ref <= n_ref + 1;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] onehot(input logic [2:0] x);
        return 8'h01 << x;
    endfunction : onehot
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic w1;
        @(posedge ck);
        #1;
    endtask : w1
    task automatic w2;
        @(posedge ck);
        @(posedge ck);
        #1;
    endtask : w2
    task automatic report_and_stop;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #100000;
        miscompares++;
        report_and_stop;
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        ck_run = 1'b1;
        pd_dll_fast = 1'b0;
        repeat (5) @(posedge clock);
        @(negedge clock) resetn = 1'b1;
        b = 3'($random(seed));
        pm.send(`DRP_CMD_ACT, 1'b1, b, 1'b0);
        w2;
        check(16'(bank_open), 16'(onehot(b)));
        open0 = bank_open;
        for (int i = 0; i < 5; i++) begin
            e = (i == 0) ? 1'b1 : 1'($random(seed));
            pm.send(`DRP_CMD_WR, 1'b1, b, e);
            w1;
            check(16'(wr_suspect), 16'(e));
            w1;
            check(16'(bank_open), 16'(open0));
        end
        pm.send(`DRP_CMD_NOP, 1'b0, 3'h0, 1'b0);
        w2;
        check(16'(dev_state), 16'(ST_PD_ACT));
        check(16'(dll_enable), 16'h0000);
        repeat (3) @(posedge ck);
        #1;
        check(16'(cmd_rx_en), 16'h0000);
        pm.send(`DRP_CMD_ACT, 1'b0, ~b, 1'b0);
        w2;
        check(16'(bank_open), 16'(open0));
        pm.send(`DRP_CMD_NOP, 1'b1, 3'h0, 1'b0);
        w2;
        check(16'(dev_state), 16'(ST_NORMAL));
        check(16'(cmd_rx_en), 16'h0001);
        pm.send(`DRP_CMD_PRE, 1'b1, 3'h0, 1'b0);
        w2;
        check(16'(bank_open), 16'h0000);
        n0 = n_ref;
        pm.send(`DRP_CMD_REF, 1'b1, 3'($random(seed)), 1'b0);
        w2;
        check(16'(dev_state), 16'(ST_REFRESH));
        pm.send(`DRP_CMD_ACT, 1'b1, b, 1'b0);
        w2;
        check(16'(bank_open), 16'h0000);
        repeat (TRFC) @(posedge ck);
        #1;
        check(16'(dev_state), 16'(ST_NORMAL));
        check(16'(n_ref - n0), 16'h0001);
        check(16'(refresh_row), 16'(n_ref));
        for (int f = 0; f < 2; f++) begin
            @(negedge clock) pd_dll_fast = f[0];
            pm.send(`DRP_CMD_NOP, 1'b0, 3'h0, 1'b0);
            w2;
            check(16'(dev_state), 16'(ST_PD_PRE));
            check(16'(dll_enable), 16'(f[0]));
            pm.send(`DRP_CMD_NOP, 1'b1, 3'h0, 1'b0);
            w2;
            check(16'(dll_enable), 16'h0001);
        end
        n0 = n_ref;
        pm.send(`DRP_CMD_REF, 1'b0, 3'h0, 1'b0);
        w2;
        check(16'(dev_state), 16'(ST_SELF_REF));
        check(16'(dll_enable), 16'h0000);
        repeat (6) @(posedge clock);
        #1;
        check(16'(n_ref - n0 >= 1), 16'h0001);
        pm.send(`DRP_CMD_ACT, 1'b0, b, 1'b0);
        @(negedge ck) ck_run = 1'b0;
        repeat (100) @(posedge clock);
        ck_run = 1'b1;
        repeat (4) @(posedge ck);
        #1;
        check(16'(bank_open), 16'h0000);
        check(16'(n_ref - n0 >= 5), 16'h0001);
        check(16'(refresh_row), 16'(n_ref));
        pm.send(`DRP_CMD_NOP, 1'b1, 3'h0, 1'b0);
        w1;
        check(16'(dll_reset), 16'h0001);
        w1;
        check(16'(dev_state), 16'(ST_NORMAL));
        check(16'(dll_reset), 16'h0000);
        check(16'(dll_enable), 16'h0001);
        pm.send(`DRP_CMD_NOP, 1'b0, 3'h0, 1'b0);
        w2;
        @(negedge clock) resetn = 1'b0;
        pm.cke = 1'b1;
        repeat (5) @(posedge clock);
        @(negedge clock) resetn = 1'b1;
        #1;
        check(16'(dev_state), 16'(ST_NORMAL));
        check(16'(cmd_rx_en), 16'h0001);
        check(16'(dll_enable), 16'h0000);
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
